//--- hw/flash_boot_protect_control.sv
// Flash boot-area selection, rewrite gating, code protect and ID check
//
// Overview of operation
// - Reset with boot strap low, test and serial straps high enters boot mode.
// - Test strap low at reset runs user area and blocks boot-area reads.
// - In boot mode the area-select bit maps boot or user area.
// - Boot area is one 4 Kbyte block overlapping the user area top.
// - Boot area is rewritten only in parallel mode, never by CPU or serial.
// - User area blocks carry lock bits; locked blocks refuse program and erase.
// - Seven software commands; program per word, erase per whole block.
// - RAM sub-mode refuses rewrite commands while CPU fetches from flash; in-place allows.
// - Serial programming offers clock-synchronous and UART link variants.
// - Protect active when release field nonzero and a level bit is zero.
// - Release field 00 lets parallel reads and rewrites through.
// - Active protection stops parallel mode changing the release field.
// - Serial mode compares programmer ID bytes; a mismatch rejects later commands.
// - Seven 8-bit ID bytes compared in order from the first.
// - Rewrite mode forces mode bits 0 and 3; bit 3 writes apply afterwards.
`timescale 1ns/1ns
`default_nettype none
`include "fbpc_defines.svh"

module flash_boot_protect_control (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // Strap pins
  input  wire logic        boot_select_strap,
  input  wire logic        test_mode_strap,
  input  wire logic        serial_boot_strap,
  input  wire logic        parallel_mode_strap,
  input  wire logic        serial_link_uart_strap,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // CPU fetch location
  input  wire logic        cpu_fetch_in_flash,
  // Flash readout of ID bytes and code-protect word
  input  wire logic        load_valid,
  input  wire logic [2:0]  load_idx,
  input  wire logic [7:0]  load_data,
  // Programmer command port
  input  wire logic        prog_req,
  input  wire logic [2:0]  prog_cmd,
  input  wire logic [19:0] prog_addr,
  input  wire logic        prog_boot_area,
  input  wire logic [15:0] prog_wdata,
  input  wire logic        prog_id_valid,
  input  wire logic [7:0]  prog_id_byte,
  output logic             prog_ack,
  output logic             prog_refused,
  output logic             prog_id_fail,
  // Flash array
  input  wire logic        flash_busy,
  input  wire logic        flash_error,
  output logic             flash_start,
  output logic      [2:0]  flash_op,
  output logic      [19:0] flash_addr,
  output logic      [15:0] flash_wdata,
  output logic             flash_boot_sel,
  // Mode and map outputs
  output logic             exec_from_boot,
  output logic             map_boot_area,
  output logic             boot_read_block,
  output logic             cpu_hold,
  output logic      [7:0]  pm1_value,
  output logic             serial_link_uart
);

  // ==========================================================
  // Shared decoders
  function automatic logic [2:0] block_of(input logic [19:0] a);
    block_of = a[`FBPC_BLOCK_LSB +: 3];
  endfunction : block_of

  function automatic logic is_rewrite(input logic [2:0] c);
    is_rewrite = (c == fbpc_pkg::CMD_PROGRAM) || (c == fbpc_pkg::CMD_BLOCK_ERASE) ||
                 (c == fbpc_pkg::CMD_LOCK_PROG);
  endfunction : is_rewrite

  function automatic logic is_boot_addr(input logic [19:0] a);
    is_boot_addr = a[19:`FBPC_BOOT_TAG_LSB] == `FBPC_BOOT_TAG;
  endfunction : is_boot_addr

  // ==========================================================
  // Strap synchronisers: stage one feeds stage two only
  logic [4:0] strap_s1;
  logic [4:0] strap_s2;
  wire  [4:0] strap_pins = {serial_link_uart_strap, parallel_mode_strap, serial_boot_strap,
                            test_mode_strap, boot_select_strap};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_s1 <= 5'h00;
      strap_s2 <= 5'h00;
    end else if (clk_en) begin
      strap_s1 <= strap_pins;
      strap_s2 <= strap_s1;
    end
  end

  // ==========================================================
  // Strap capture after reset; modes hold until next reset
  fbpc_pkg::fbpc_state_t state;
  fbpc_pkg::fbpc_state_t next_state;
  logic [1:0] wait_cnt;
  logic       boot_mode;
  logic       user_exec;
  logic       parallel_mode;
  logic       uart_variant;
  wire        cap_boot = strap_s2[1] && strap_s2[2] && !strap_s2[0];
  wire        cap_par  = strap_s2[1] && strap_s2[3] && !cap_boot;
  wire        running  = state == fbpc_pkg::ST_RUN;

  always_comb begin
    next_state = state;
    unique case (state)
      fbpc_pkg::ST_HOLD:    next_state = (wait_cnt == `FBPC_SYNC_WAIT) ? fbpc_pkg::ST_CAPTURE : state;
      fbpc_pkg::ST_CAPTURE: next_state = fbpc_pkg::ST_RUN;
      fbpc_pkg::ST_RUN:     next_state = state;
      default:              next_state = fbpc_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state    <= fbpc_pkg::ST_HOLD;
      wait_cnt <= 2'h0;
    end else if (clk_en) begin
      state    <= next_state;
      wait_cnt <= (state == fbpc_pkg::ST_HOLD) ? wait_cnt + 2'h1 : 2'h0;
    end
  end

  // Mode latches taken in the capture state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      boot_mode     <= 1'b0;
      user_exec     <= 1'b0;
      parallel_mode <= 1'b0;
      uart_variant  <= 1'b0;
    end else if (clk_en && state == fbpc_pkg::ST_CAPTURE) begin
      boot_mode     <= cap_boot;
      user_exec     <= !strap_s2[1];
      parallel_mode <= cap_par;
      uart_variant  <= strap_s2[4];
    end
  end

  // ==========================================================
  // Register write decode
  wire wr_ctrl  = reg_wr && reg_addr == `FBPC_REG_CTRL;
  wire wr_cmd   = reg_wr && reg_addr == `FBPC_REG_CMD;
  wire wr_pm1   = reg_wr && reg_addr == `FBPC_REG_PM1;

  // Control bits; rewrite enable and in-place need a 0 write then a 1 write
  logic [1:0]  ctrl_seq;
  logic [1:0]  arm;
  logic        lock_dis;
  logic        area_sel;
  logic [19:0] cmd_addr;
  logic [15:0] cmd_data;
  wire         rewrite_en = ctrl_seq[0];
  wire         inplace    = ctrl_seq[1];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_seq
      wire allow = (g == 0) ? running : ctrl_seq[0];
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          ctrl_seq[g] <= 1'b0;
          arm[g]      <= 1'b0;
        end else if (clk_en) begin
          if (g == 1 && !ctrl_seq[0]) begin
            ctrl_seq[g] <= 1'b0;
            arm[g]      <= 1'b0;
          end else if (wr_ctrl) begin
            ctrl_seq[g] <= reg_wdata[g] && arm[g] && allow;
            arm[g]      <= !reg_wdata[g];
          end
        end
      end
    end
  endgenerate

  // Plain control and command operand registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lock_dis <= 1'b0;
      area_sel <= 1'b0;
      cmd_addr <= 20'h00000;
      cmd_data <= 16'h0000;
    end else if (clk_en && reg_wr) begin
      if (wr_ctrl) lock_dis <= reg_wdata[`FBPC_CTRL_LOCKDIS];
      if (wr_ctrl) area_sel <= reg_wdata[`FBPC_CTRL_AREA];
      if (reg_addr == `FBPC_REG_ADDR_L) cmd_addr[7:0]   <= reg_wdata;
      if (reg_addr == `FBPC_REG_ADDR_M) cmd_addr[15:8]  <= reg_wdata;
      if (reg_addr == `FBPC_REG_ADDR_H) cmd_addr[19:16] <= reg_wdata[3:0];
      if (reg_addr == `FBPC_REG_DATA_L) cmd_data[7:0]   <= reg_wdata;
      if (reg_addr == `FBPC_REG_DATA_H) cmd_data[15:8]  <= reg_wdata;
    end
  end

  // ==========================================================
  // Code-protect word and ID store loading from the flash readout
  logic [7:0] cp_word;
  logic [6:0] id_nonblank;
  fbpc_id_if  id_bus ();

  wire [1:0] cp_rel    = cp_word[`FBPC_CP_REL_LSB +: 2];
  wire [1:0] cp_lvl    = cp_word[`FBPC_CP_LVL_LSB +: 2];
  wire       rel_open  = cp_rel == `FBPC_CP_REL_OPEN;
  wire       cp_active = !rel_open && (cp_lvl != `FBPC_CP_LVL_OFF);
  wire       id_blank  = id_nonblank == 7'h00;
  wire       load_id   = load_valid && load_idx != `FBPC_LOAD_CP_IDX;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cp_word     <= `FBPC_CP_RESET;
      id_nonblank <= 7'h00;
    end else if (clk_en && load_valid) begin
      if (!load_id) cp_word <= load_data;
      if (load_id) id_nonblank[load_idx] <= load_data != `FBPC_ERASED_BYTE;
    end
  end

  // ==========================================================
  // ID comparison; bytes need one idle cycle between them
  logic [2:0] id_idx;
  logic       id_pend;
  logic [7:0] id_byte_q;
  logic       id_fail;
  wire        id_done = id_idx == `FBPC_ID_BYTES;
  wire        id_ok   = id_blank || (id_done && !id_fail);
  wire        id_take = prog_id_valid && !id_pend && !id_done && !id_fail && !id_blank;

  assign id_bus.wr_en   = clk_en && load_id;
  assign id_bus.wr_idx  = load_idx;
  assign id_bus.wr_data = load_data;
  assign id_bus.rd_idx  = id_idx;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      id_idx    <= 3'h0;
      id_pend   <= 1'b0;
      id_byte_q <= 8'h00;
      id_fail   <= 1'b0;
    end else if (clk_en) begin
      id_pend <= id_take;
      if (id_take) id_byte_q <= prog_id_byte;
      if (id_pend && id_byte_q != id_bus.rd_data) id_fail <= 1'b1;
      if (id_pend) id_idx <= id_idx + 3'h1;
    end
  end

  fbpc_id_store u_id_store (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .id      (id_bus)
  );

  // ==========================================================
  // Lock bits per user block
  logic [7:0] lock_bits;

  // ==========================================================
  // Command gating; the start pulse counts as busy
  wire       busy_any   = flash_busy || flash_start;
  wire [2:0] cpu_cmd    = reg_wdata[2:0];
  wire [2:0] cpu_blk    = block_of(cmd_addr);
  wire       cpu_rw     = is_rewrite(cpu_cmd);
  wire       cpu_boot   = boot_mode && !area_sel;
  wire       cpu_locked = lock_bits[cpu_blk] && !lock_dis;
  wire       cpu_fetchx = !inplace && cpu_fetch_in_flash;
  wire       cpu_ok     = rewrite_en && !parallel_mode && !busy_any && cpu_cmd != 3'h7 &&
                          !(cpu_rw && (cpu_boot || cpu_locked || cpu_fetchx));
  wire [2:0] pg_blk     = block_of(prog_addr);
  wire       pg_rw      = is_rewrite(prog_cmd);
  wire       pg_boot    = parallel_mode ? prog_boot_area : is_boot_addr(prog_addr);
  wire       pg_gate    = parallel_mode ? !cp_active : (boot_mode && id_ok && !pg_boot);
  wire       pg_ok      = prog_req && running && !busy_any && prog_cmd != 3'h7 && pg_gate &&
                          !(pg_rw && !pg_boot && lock_bits[pg_blk]);
  wire       cpu_go     = wr_cmd && cpu_ok && !pg_ok;
  wire       any_go     = pg_ok || cpu_go;
  wire [2:0] go_cmd     = pg_ok ? prog_cmd : cpu_cmd;
  wire [2:0] go_blk     = pg_ok ? pg_blk : cpu_blk;
  wire [19:0] go_addr   = pg_ok ? prog_addr : cmd_addr;
  wire [4:0] go_addr_hi = go_addr[19:15];
  wire       go_boot    = pg_ok ? (parallel_mode && pg_boot) : cpu_boot;
  wire       go_clear   = cpu_go && cpu_cmd == fbpc_pkg::CMD_CLEAR_STAT;

  // Lock program sets the block lock; erase with locks disabled clears it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lock_bits <= 8'h00;
    end else if (clk_en && any_go && !go_boot) begin
      if (go_cmd == fbpc_pkg::CMD_LOCK_PROG) lock_bits[go_blk] <= 1'b1;
      if (go_cmd == fbpc_pkg::CMD_BLOCK_ERASE && cpu_go && lock_dis) lock_bits[go_blk] <= 1'b0;
    end
  end

  // Flash array request; erase addresses the whole block
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flash_start    <= 1'b0;
      flash_op       <= 3'h0;
      flash_addr     <= 20'h00000;
      flash_wdata    <= 16'h0000;
      flash_boot_sel <= 1'b0;
    end else if (clk_en) begin
      flash_start <= any_go;
      if (any_go) begin
        flash_op       <= go_cmd;
        flash_addr     <= (go_cmd == fbpc_pkg::CMD_BLOCK_ERASE) ?
                          {go_addr_hi, 15'h0000} : go_addr;
        flash_wdata    <= pg_ok ? prog_wdata : cmd_data;
        flash_boot_sel <= go_boot;
      end
    end
  end

  // Programmer answers and sticky status; a set wins over a clear
  logic refused;
  logic flash_err;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prog_ack     <= 1'b0;
      prog_refused <= 1'b0;
      prog_id_fail <= 1'b0;
      refused      <= 1'b0;
      flash_err    <= 1'b0;
    end else if (clk_en) begin
      prog_ack     <= pg_ok;
      prog_refused <= prog_req && !pg_ok;
      prog_id_fail <= id_fail;
      refused      <= (wr_cmd && !cpu_go) || (refused && !go_clear);
      flash_err    <= flash_error || (flash_err && !go_clear);
    end
  end

  // ==========================================================
  // Processor mode register one; bit 3 writes wait for rewrite clear
  logic [7:0] pm1_sw;
  logic       pm1_b3_shadow;
  logic       rewrite_q;
  wire        rewrite_fall = rewrite_q && !rewrite_en;
  wire [7:0]  next_pm1_sw  = wr_pm1 ?
                             (rewrite_en ? {reg_wdata[7:4], pm1_sw[3], reg_wdata[2:0]} : reg_wdata) :
                             (rewrite_fall ? {pm1_sw[7:4], pm1_b3_shadow, pm1_sw[2:0]} : pm1_sw);
  wire        next_shadow  = (rewrite_en && wr_pm1) ? reg_wdata[`FBPC_PM1_DEFER_BIT] :
                             (rewrite_en ? pm1_b3_shadow : next_pm1_sw[`FBPC_PM1_DEFER_BIT]);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pm1_sw        <= `FBPC_PM1_RESET;
      pm1_b3_shadow <= 1'b0;
      rewrite_q     <= 1'b0;
      pm1_value     <= `FBPC_PM1_RESET;
    end else if (clk_en) begin
      pm1_sw        <= next_pm1_sw;
      pm1_b3_shadow <= next_shadow;
      rewrite_q     <= rewrite_en;
      pm1_value     <= rewrite_en ? (next_pm1_sw | `FBPC_PM1_FORCE_MASK) : next_pm1_sw;
    end
  end

  // ==========================================================
  // Map and mode outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      exec_from_boot   <= 1'b0;
      map_boot_area    <= 1'b0;
      boot_read_block  <= 1'b1;
      cpu_hold         <= 1'b0;
      serial_link_uart <= 1'b0;
    end else if (clk_en) begin
      exec_from_boot   <= boot_mode;
      map_boot_area    <= boot_mode && !area_sel;
      boot_read_block  <= !boot_mode && !parallel_mode;
      cpu_hold         <= rewrite_en && inplace && flash_busy;
      serial_link_uart <= uart_variant;
    end
  end

  // ==========================================================
  // Register read; unmapped and write-only offsets read zero
  wire [7:0] st_word = {flash_err, refused, id_ok, cp_active, parallel_mode, user_exec, boot_mode, !flash_busy};
  wire [7:0] ctrl_rd = {2'h0, area_sel, 2'h0, lock_dis, inplace, rewrite_en};
  wire [7:0] rd_mux  = (reg_addr == `FBPC_REG_CTRL)   ? ctrl_rd :
                       (reg_addr == `FBPC_REG_STATUS) ? st_word :
                       (reg_addr == `FBPC_REG_ADDR_L) ? cmd_addr[7:0] :
                       (reg_addr == `FBPC_REG_ADDR_M) ? cmd_addr[15:8] :
                       (reg_addr == `FBPC_REG_ADDR_H) ? {4'h0, cmd_addr[19:16]} :
                       (reg_addr == `FBPC_REG_DATA_L) ? cmd_data[7:0] :
                       (reg_addr == `FBPC_REG_DATA_H) ? cmd_data[15:8] :
                       (reg_addr == `FBPC_REG_PM1)    ? pm1_value :
                       (reg_addr == `FBPC_REG_LOCK)   ? lock_bits :
                       (reg_addr == `FBPC_REG_CPWORD) ? cp_word : 8'h00;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule : flash_boot_protect_control

`default_nettype wire

//--- hw/fbpc_defines.svh
// Register offsets, field positions, reset values and timing counts of the flash boot/protect control
`ifndef FBPC_DEFINES_SVH
`define FBPC_DEFINES_SVH

// ==========================================================
// Register offsets (register port address)
`define FBPC_REG_CTRL        4'h0
`define FBPC_REG_STATUS      4'h1
`define FBPC_REG_CMD         4'h2
`define FBPC_REG_ADDR_L      4'h3
`define FBPC_REG_ADDR_M      4'h4
`define FBPC_REG_ADDR_H      4'h5
`define FBPC_REG_DATA_L      4'h6
`define FBPC_REG_DATA_H      4'h7
`define FBPC_REG_PM1         4'h8
`define FBPC_REG_LOCK        4'h9
`define FBPC_REG_CPWORD      4'hA

// ==========================================================
// Control register fields
`define FBPC_CTRL_REWRITE    0
`define FBPC_CTRL_INPLACE    1
`define FBPC_CTRL_LOCKDIS    2
`define FBPC_CTRL_AREA       5

// ==========================================================
// Status register fields
`define FBPC_ST_READY        0
`define FBPC_ST_BOOT         1
`define FBPC_ST_USER         2
`define FBPC_ST_PARALLEL     3
`define FBPC_ST_CPACT        4
`define FBPC_ST_IDOK         5
`define FBPC_ST_REFUSED      6
`define FBPC_ST_ERROR        7

// ==========================================================
// Code-protect word layout and reset
`define FBPC_CP_REL_LSB      2
`define FBPC_CP_LVL_LSB      6
`define FBPC_CP_RESET        8'hFF
`define FBPC_CP_REL_OPEN     2'h0
`define FBPC_CP_LVL_OFF      2'h3

// ==========================================================
// ID code store
`define FBPC_ID_BYTES        3'h7
`define FBPC_LOAD_CP_IDX     3'h7
`define FBPC_ERASED_BYTE     8'hFF

// ==========================================================
// Address map: boot area is one 4 Kbyte block at the top
`define FBPC_BOOT_TAG        8'hFF
`define FBPC_BOOT_TAG_LSB    12
`define FBPC_BLOCK_LSB       15

// ==========================================================
// Processor mode register one
`define FBPC_PM1_RESET       8'h00
`define FBPC_PM1_FORCE_MASK  8'h09
`define FBPC_PM1_DEFER_BIT   3

// ==========================================================
// Strap capture: enabled cycles for the synchronisers to fill
`define FBPC_SYNC_WAIT       2'h2

`endif

//--- hw/fbpc_pkg.sv
// Types shared by the flash boot/protect control files
package fbpc_pkg;

  // ==========================================================
  // Strap capture sequence
  typedef enum logic [2:0] {
    ST_HOLD    = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_RUN     = 3'b100
  } fbpc_state_t;

  // ==========================================================
  // The seven flash software commands; code 7 is illegal
  typedef enum logic [2:0] {
    CMD_READ_ARRAY  = 3'h0,
    CMD_READ_STATUS = 3'h1,
    CMD_CLEAR_STAT  = 3'h2,
    CMD_PROGRAM     = 3'h3,
    CMD_BLOCK_ERASE = 3'h4,
    CMD_LOCK_PROG   = 3'h5,
    CMD_READ_LOCK   = 3'h6
  } fbpc_cmd_t;

endpackage : fbpc_pkg

//--- hw/fbpc_id_if.sv
// Carrier between the controller and the ID code store
`timescale 1ns/1ns
`default_nettype none

interface fbpc_id_if;
  logic       wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [2:0] rd_idx;
  logic [7:0] rd_data;

  modport ctrl  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : fbpc_id_if

`default_nettype wire

//--- hw/fbpc_id_store.sv
// Seven-byte store of the ID code read out of flash, registered read port
`timescale 1ns/1ns
`default_nettype none
`include "fbpc_defines.svh"

module fbpc_id_store (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic clk_en,
  // Store port
  fbpc_id_if.store  id
);

  logic [7:0] mem [0:6];
  wire        wr_hit = id.wr_en && (id.wr_idx < `FBPC_ID_BYTES);
  wire        rd_hit = id.rd_idx < `FBPC_ID_BYTES;

  // ==========================================================
  // Storage; contents need no reset, the readout reloads them
  always_ff @(posedge clk_sys) begin
    if (clk_en && wr_hit) begin
      mem[id.wr_idx] <= id.wr_data;
    end
  end

  // Out-of-range index reads as erased so it can never match by accident
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      id.rd_data <= 8'h00;
    end else if (clk_en) begin
      id.rd_data <= rd_hit ? mem[id.rd_idx] : `FBPC_ERASED_BYTE;
    end
  end

endmodule : fbpc_id_store

`default_nettype wire

//--- tb/fbpc_checker.sv
// Port checker of the flash boot/protect control
`timescale 1ns/1ns
`default_nettype none
module fbpc_checker (
  // Clock, reset and watched ports
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        exec_from_boot,
  input wire logic        boot_read_block,
  input wire logic        map_boot_area,
  input wire logic        prog_req,
  input wire logic [19:0] prog_addr,
  input wire logic        prog_ack,
  input wire logic        prog_refused,
  input wire logic        prog_id_fail,
  input wire logic        flash_start
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // One answer per request keeps the programmer from hanging
  sequence answer_s; prog_ack ^ prog_refused; endsequence
  answer_due_a: assert property (prog_req |=> answer_s) else $error("request unanswered");
  ack_start_a: assert property (prog_ack |-> flash_start) else $error("ack without flash start");
  start_pulse_a: assert property (flash_start |=> !flash_start) else $error("start too long");
  boot_open_a: assert property (exec_from_boot |-> !boot_read_block) else $error("boot reads blocked");
  map_in_boot_a: assert property (map_boot_area |-> exec_from_boot) else $error("boot map outside boot");
  id_sticky_a: assert property (prog_id_fail |=> prog_id_fail) else $error("id failure dropped");
  id_reject_a: assert property (prog_id_fail && prog_req |=> prog_refused) else $error("accepted after id fail");
  boot_serial_a: assert property (exec_from_boot && prog_req && prog_addr[19:12] == 8'hFF |=> prog_refused)
    else $error("serial rewrite of boot area");
endmodule : fbpc_checker
bind flash_boot_protect_control fbpc_checker chk (.*);
`default_nettype wire

//--- tb/fbpc_prog_model.sv
// Model of the external serial programmer
`timescale 1ns/1ns
`default_nettype none
module fbpc_prog_model (
  // Clock and programmer port
  input  wire logic        clk_sys,
  output var logic         prog_req,
  output var logic  [2:0]  prog_cmd,
  output var logic  [19:0] prog_addr,
  output var logic         prog_boot_area,
  output var logic  [15:0] prog_wdata,
  output var logic         prog_id_valid,
  output var logic  [7:0]  prog_id_byte
);
  // Released lines show the inverse so stale values never match
  initial {prog_req, prog_cmd, prog_addr, prog_boot_area, prog_wdata, prog_id_valid, prog_id_byte} = '0;
  // Word program over the synchronous link, then room for the flash to finish
  task automatic send_word(input logic [19:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    {prog_req, prog_cmd, prog_addr, prog_wdata} <= {1'b1, fbpc_pkg::CMD_PROGRAM, a, d};
    @(posedge clk_sys);
    {prog_req, prog_addr, prog_wdata} <= {1'b0, ~a, ~d};
    repeat (3) @(posedge clk_sys);
  endtask : send_word
  // ID bytes three edges apart, first byte first
  task automatic send_id(input logic [7:0] b);
    @(posedge clk_sys);
    {prog_id_valid, prog_id_byte} <= {1'b1, b};
    @(posedge clk_sys);
    {prog_id_valid, prog_id_byte} <= {1'b0, ~b};
    @(posedge clk_sys);
  endtask : send_id
endmodule : fbpc_prog_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench of the flash boot/protect control
`timescale 1ns/1ns
`default_nettype none
`include "fbpc_defines.svh"
module tb_top;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk_sys, resetn, boot_select_strap, test_mode_strap, serial_boot_strap, reg_wr, reg_rd, rd_d;
  logic        load_valid, flash_busy, prog_req, prog_boot_area, prog_id_valid, prog_ack, prog_refused;
  logic        prog_id_fail, flash_start, exec_from_boot, boot_read_block, serial_link_uart, flash_error;
  logic        serial_link_uart_strap, cpu_fetch_in_flash;
  logic [2:0]  prog_cmd, load_idx;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, load_data, prog_id_byte, id_b [7], exp_q [$];
  logic [15:0] prog_wdata;
  logic [19:0] prog_addr;
  integer      seed = 99, num_errors = 0, cmp_count = 0, cyc = 0;
  flash_boot_protect_control uut (.*, .clk_en(1'b1), .parallel_mode_strap(1'b0), .flash_op(), .flash_addr(),
    .flash_wdata(), .flash_boot_sel(), .map_boot_area(), .cpu_hold(), .pm1_value());
  fbpc_prog_model pm (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Single-cycle register strobe, data due in the following cycle
  task automatic reg_access(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'b00;
  endtask : reg_access
  // Straps set under reset, then ID bytes and protect word load
  task automatic restart(input logic b, input logic t, input logic s);
    @(posedge clk_sys);
    {resetn, boot_select_strap, test_mode_strap, serial_boot_strap, serial_link_uart_strap} <= {1'b0, b, t, s, !s};
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      {load_valid, load_idx, load_data} <= {1'b1, 3'(i), (i == 7) ? 8'hFF : id_b[i % 7]};
    end
    @(posedge clk_sys);
    load_valid <= 1'b0;
  endtask : restart
  // ==========================================================
  // Watcher: each answer or read result against the oldest note
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    flash_busy <= flash_start;
    {cpu_fetch_in_flash, flash_error} <= 2'($random(seed));
    if (rd_d || prog_ack || prog_refused) check("answer", rd_d ? reg_rdata : {7'h00, prog_ack}, exp_q.pop_front());
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    {resetn, boot_select_strap, test_mode_strap, serial_boot_strap, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata, load_valid, load_idx, load_data} = '0;
    for (int i = 0; i < 7; i++) id_b[i] = 8'($random(seed));
    id_b[0][0] = 1'b0; // Keeps the store from reading as blank
    // Boot mode: matching ID lets user writes through, boot area stays shut
    restart(1'b0, 1'b1, 1'b1);
    check("boot exec", {6'h00, serial_link_uart, exec_from_boot}, 8'h01);
    for (int i = 0; i < 7; i++) pm.send_id(id_b[i]);
    exp_q.push_back(8'h01);
    pm.send_word(20'h01000, 16'($random(seed)));
    exp_q.push_back(8'h00);
    pm.send_word(20'hFF800, 16'($random(seed)));
    // Wrong first byte: sticky failure, later commands refused
    restart(1'b0, 1'b1, 1'b1);
    pm.send_id(~id_b[0]);
    repeat (2) @(posedge clk_sys);
    check("id fail", {7'h00, prog_id_fail}, 8'h01);
    exp_q.push_back(8'h00);
    pm.send_word(20'h01000, 16'h1234);
    // User mode: boot reads blocked, rewrite forces mode bits, bit 3 deferred
    restart(1'b1, 1'b0, 1'b0);
    check("boot block", {6'h00, serial_link_uart, boot_read_block}, 8'h03);
    reg_access(1'b1, `FBPC_REG_CTRL, 8'h20);
    reg_access(1'b1, `FBPC_REG_CTRL, 8'h21);
    reg_access(1'b1, `FBPC_REG_PM1, 8'h08);
    exp_q.push_back(8'h09);
    reg_access(1'b0, `FBPC_REG_PM1, 8'h00);
    reg_access(1'b1, `FBPC_REG_CTRL, 8'h00);
    exp_q.push_back(8'h08);
    reg_access(1'b0, `FBPC_REG_PM1, 8'h00);
    exp_q.push_back(8'h00);
    reg_access(1'b0, 4'hF, 8'h00);
    repeat (3) @(posedge clk_sys);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
